// ### dcff_pkg.sv
// shared constants, types and helpers of the single-clock buffer flag block
//
// Contract
// - two 12-bit distance registers from data 0-11
// - first offset write loads empty-side distance
// - later offset writes alternate full, empty, full
// - leaving load mode keeps the offset sequence
// - unprogrammed distances take depth-dependent defaults
// - offset reads present distances in same order
// - full flag low when full, blocks writes
// - empty flag low when empty, blocks reads
// - almost flags low within programmed distance
// - sync select low: almost flags clocked, else async
// - half flag low above half the depth
// - retransmit rewinds read pointer, write pointer kept
// - after rewind reads replay data, flags follow
// - depth cascade: half flag pin carries cascade
// - reset empties buffer, empty flag low
// - load high, write enable low stores word
// - reads present next word, hold last
package dcff_pkg;

    localparam int DCFF_WIDTH = 18;
    localparam int DCFF_OFS_W = 12;
    localparam int DCFF_DEPTH = 64;
    localparam int DCFF_BUF_DEPTH = 2;
    localparam logic [DCFF_WIDTH-1:0] DCFF_DATA_RST = 18'h00000;

    // per-depth default distances
    localparam logic [DCFF_OFS_W-1:0] DCFF_DEF_64 = 12'h007;
    localparam logic [DCFF_OFS_W-1:0] DCFF_DEF_256 = 12'h01f;
    localparam logic [DCFF_OFS_W-1:0] DCFF_DEF_512 = 12'h03f;
    localparam logic [DCFF_OFS_W-1:0] DCFF_DEF_1K = 12'h07f;

    typedef struct packed {
        logic full_n;
        logic almost_full_n;
        logic half_full_n;
        logic almost_empty_n;
        logic empty_n;
    } dcff_flags_t;

    localparam dcff_flags_t DCFF_FLAGS_RST = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

    function automatic logic [DCFF_OFS_W-1:0] dcff_default_offset(input int depth);
        if (depth <= 64)
        begin
            return DCFF_DEF_64;
        end
        else if (depth <= 256)
        begin
            return DCFF_DEF_256;
        end
        else if (depth <= 512)
        begin
            return DCFF_DEF_512;
        end
        return DCFF_DEF_1K;
    endfunction

endpackage

// ### dcff_buf2.sv
// two-entry valid/ready buffer in front of the storage array
`timescale 1ns/1ps
`default_nettype none
module dcff_buf2
    import dcff_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // filling side
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [DCFF_WIDTH-1:0] i_data,
    // draining side
    output logic o_valid,
    input wire logic i_ready,
    output logic [DCFF_WIDTH-1:0] o_data,
    output logic [1:0] o_count
);
    logic [DCFF_WIDTH-1:0] slot_ff [DCFF_BUF_DEPTH];
    logic head_ff;
    logic [1:0] count_ff;
    logic push;
    logic pop;
    logic tail;

    assign o_ready = (count_ff != 2'h2);
    assign o_valid = (count_ff != 2'h0);
    assign o_data = slot_ff[head_ff];
    assign o_count = count_ff;
    assign push = i_valid & o_ready;
    assign pop = o_valid & i_ready;
    assign tail = head_ff ^ count_ff[0];

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            count_ff <= 2'h0;
            head_ff <= 1'b0;
        end
        else
        begin
            count_ff <= count_ff + {1'b0, push} - {1'b0, pop};
            if (pop)
            begin
                head_ff <= ~head_ff;
            end
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (push)
        begin
            slot_ff[tail] <= i_data;
        end
    end
endmodule // dcff_buf2
`default_nettype wire

// ### dcff_core.sv
// flag, offset, retransmit and cascade logic of the 18-bit buffer
`timescale 1ns/1ps
`default_nettype none
module dcff_core
    import dcff_pkg::*;
#(
    parameter int DEPTH = DCFF_DEPTH
)
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // write side
    input wire logic i_wr_en_n,
    input wire logic [DCFF_WIDTH-1:0] i_data,
    output logic o_wr_ready,
    // read side
    input wire logic i_rd_en_n,
    output logic [DCFF_WIDTH-1:0] o_data,
    // control straps and strobes
    input wire logic i_offset_load_n,
    input wire logic i_retransmit_pulse,
    input wire logic i_almost_flag_sync_select,
    input wire logic i_depth_cascade,
    input wire logic i_first_device_select,
    // cascade chain
    input wire logic i_write_cascade_in,
    input wire logic i_read_cascade_in,
    output logic o_write_cascade_out,
    output logic o_read_cascade_out,
    // status
    output dcff_flags_t o_flags
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [CW-1:0] HALF_CNT = CW'(DEPTH / 2);
    localparam logic [DCFF_OFS_W-1:0] DEF_OFS = dcff_default_offset(DEPTH);

    ////////////////////////////////////////////////////////////////////////////
    // storage and pointers
    logic [DCFF_WIDTH-1:0] mem_ff [DEPTH];
    logic [CW-1:0] wr_ptr_ff;
    logic [CW-1:0] rd_ptr_ff;
    logic [CW-1:0] nxt_wr_ptr;
    logic [CW-1:0] nxt_rd_ptr;
    logic [CW-1:0] mem_cnt;
    logic [CW-1:0] nxt_mem_cnt;
    logic [CW-1:0] nxt_total;
    logic [CW-1:0] total;
    logic [DCFF_OFS_W-1:0] ae_dist_ff;
    logic [DCFF_OFS_W-1:0] af_dist_ff;
    logic wr_sel_ff;
    logic rd_sel_ff;
    logic wr_tok_ff;
    logic rd_tok_ff;
    logic wco_ff;
    logic rco_ff;
    dcff_flags_t flags_ff;
    logic wr_tok;
    logic rd_tok;
    logic in_valid;
    logic push;
    logic drain;
    logic buf_valid;
    logic [DCFF_WIDTH-1:0] buf_data;
    logic [1:0] buf_cnt;
    logic [1:0] nxt_buf_cnt;
    logic rd_word;
    logic ofs_wr;
    logic ofs_rd;
    logic ae_async_n;
    logic af_async_n;

    assign wr_tok = ~i_depth_cascade | wr_tok_ff;
    assign rd_tok = ~i_depth_cascade | rd_tok_ff;
    // full flag gates the word before it reaches the buffer
    assign in_valid = i_offset_load_n & ~i_wr_en_n & flags_ff.full_n & wr_tok;
    assign drain = buf_valid & (mem_cnt != FULL_CNT);
    assign rd_word = i_offset_load_n & ~i_rd_en_n & flags_ff.empty_n & rd_tok
        & ~i_retransmit_pulse;
    assign ofs_wr = ~i_offset_load_n & ~i_wr_en_n;
    assign ofs_rd = ~i_offset_load_n & ~i_rd_en_n;

    dcff_buf2 u_buf
    (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_valid(in_valid),
        .o_ready(o_wr_ready),
        .i_data(i_data),
        .o_valid(buf_valid),
        .i_ready(mem_cnt != FULL_CNT),
        .o_data(buf_data),
        .o_count(buf_cnt)
    );

    assign push = in_valid & o_wr_ready;
    assign nxt_buf_cnt = buf_cnt + {1'b0, push} - {1'b0, drain};
    assign mem_cnt = wr_ptr_ff - rd_ptr_ff;
    assign total = mem_cnt + CW'(buf_cnt);
    assign nxt_wr_ptr = wr_ptr_ff + CW'(drain);
    // rewind to the first physical location, writes keep going
    assign nxt_rd_ptr = i_retransmit_pulse ? '0 : rd_ptr_ff + CW'(rd_word);
    assign nxt_mem_cnt = nxt_wr_ptr - nxt_rd_ptr;
    assign nxt_total = nxt_mem_cnt + CW'(nxt_buf_cnt);

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end
        else
        begin
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (drain)
        begin
            mem_ff[wr_ptr_ff[AW-1:0]] <= buf_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // distance registers, sequence survives load going high
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            ae_dist_ff <= DEF_OFS;
            af_dist_ff <= DEF_OFS;
            wr_sel_ff <= 1'b0;
        end
        else if (ofs_wr)
        begin
            if (wr_sel_ff)
            begin
                af_dist_ff <= i_data[DCFF_OFS_W-1:0];
            end
            else
            begin
                ae_dist_ff <= i_data[DCFF_OFS_W-1:0];
            end
            wr_sel_ff <= ~wr_sel_ff;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            rd_sel_ff <= 1'b0;
        end
        else if (ofs_rd)
        begin
            rd_sel_ff <= ~rd_sel_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output word: holds the last valid read once empty
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            o_data <= DCFF_DATA_RST;
        end
        else if (ofs_rd)
        begin
            o_data <= {6'h00, rd_sel_ff ? af_dist_ff : ae_dist_ff};
        end
        else if (rd_word)
        begin
            o_data <= mem_ff[rd_ptr_ff[AW-1:0]];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // flags from next pointer distance, so they move with the edge
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            flags_ff <= DCFF_FLAGS_RST;
        end
        else
        begin
            flags_ff.full_n <= (nxt_total != FULL_CNT);
            flags_ff.empty_n <= (nxt_mem_cnt != '0);
            flags_ff.half_full_n <= ~(nxt_total > HALF_CNT);
            flags_ff.almost_empty_n <= ~(13'(nxt_mem_cnt) <= 13'(ae_dist_ff));
            flags_ff.almost_full_n <= ~(13'(FULL_CNT - nxt_total) <= 13'(af_dist_ff));
        end
    end

    // async mode trades a glitch-free edge for zero latency
    assign ae_async_n = ~(13'(mem_cnt) <= 13'(ae_dist_ff));
    assign af_async_n = ~(13'(FULL_CNT - total) <= 13'(af_dist_ff));

    always_comb
    begin
        o_flags = flags_ff;
        if (i_almost_flag_sync_select)
        begin
            o_flags.almost_empty_n = ae_async_n;
            o_flags.almost_full_n = af_async_n;
        end
        if (i_depth_cascade)
        begin
            o_flags.half_full_n = wco_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // depth cascade tokens; the first device owns both after reset
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            wr_tok_ff <= ~i_first_device_select;
            wco_ff <= 1'b0;
        end
        else
        begin
            wco_ff <= i_depth_cascade & push & (nxt_total == FULL_CNT);
            if (i_depth_cascade & push & (nxt_total == FULL_CNT))
            begin
                wr_tok_ff <= 1'b0;
            end
            else if (i_write_cascade_in)
            begin
                wr_tok_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            rd_tok_ff <= ~i_first_device_select;
            rco_ff <= 1'b0;
        end
        else
        begin
            rco_ff <= i_depth_cascade & rd_word & (nxt_mem_cnt == '0);
            if (i_depth_cascade & rd_word & (nxt_mem_cnt == '0))
            begin
                rd_tok_ff <= 1'b0;
            end
            else if (i_read_cascade_in)
            begin
                rd_tok_ff <= 1'b1;
            end
        end
    end

    assign o_write_cascade_out = wco_ff;
    assign o_read_cascade_out = rco_ff;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_full_blocks;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        !flags_ff.full_n |-> !push;
    endproperty
    a_full_blocks: assert property (p_full_blocks)
        else $error("word accepted while full");

    property p_full_exact;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (total == FULL_CNT) |-> !flags_ff.full_n;
    endproperty
    a_full_exact: assert property (p_full_exact)
        else $error("full flag high with every word occupied");

    property p_empty_holds;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (!flags_ff.empty_n && i_offset_load_n && !i_retransmit_pulse)
            |=> $stable(o_data) && $stable(rd_ptr_ff);
    endproperty
    a_empty_holds: assert property (p_empty_holds)
        else $error("read taken while empty");

    property p_ofs_first;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (ofs_wr && !wr_sel_ff) |=> (ae_dist_ff == $past(i_data[DCFF_OFS_W-1:0])) && wr_sel_ff;
    endproperty
    a_ofs_first: assert property (p_ofs_first)
        else $error("empty-side distance not loaded");

    property p_ofs_second;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (ofs_wr && wr_sel_ff) |=> (af_dist_ff == $past(i_data[DCFF_OFS_W-1:0])) && !wr_sel_ff;
    endproperty
    a_ofs_second: assert property (p_ofs_second)
        else $error("full-side distance not loaded");

    property p_ofs_nop;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (!i_offset_load_n && i_wr_en_n) |=> $stable(wr_sel_ff) && $stable(ae_dist_ff)
            && $stable(af_dist_ff);
    endproperty
    a_ofs_nop: assert property (p_ofs_nop)
        else $error("offset sequence moved without write");

    property p_half;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        flags_ff.half_full_n == !(total > HALF_CNT);
    endproperty
    a_half: assert property (p_half)
        else $error("half flag disagrees with count");

    property p_almost_empty;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        !i_almost_flag_sync_select |->
            o_flags.almost_empty_n == !(13'(mem_cnt) <= 13'(ae_dist_ff));
    endproperty
    a_almost_empty: assert property (p_almost_empty)
        else $error("almost-empty flag wrong");

    property p_rewind;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        i_retransmit_pulse |=> (rd_ptr_ff == '0) && (wr_ptr_ff == $past(nxt_wr_ptr));
    endproperty
    a_rewind: assert property (p_rewind)
        else $error("retransmit did not rewind");

    property p_reset_empty;
        @(posedge i_ref_clk)
        !i_rst_n |=> !o_flags.empty_n && (total == '0);
    endproperty
    a_reset_empty: assert property (p_reset_empty)
        else $error("reset did not empty the buffer");

    property p_cascade_half;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        i_depth_cascade |-> o_flags.half_full_n == o_write_cascade_out;
    endproperty
    a_cascade_half: assert property (p_cascade_half)
        else $error("half pin not carrying cascade");

    c_full: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) !flags_ff.full_n);
    c_rewind_read: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_retransmit_pulse ##[1:20] rd_word);
    c_ofs_read: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        ofs_rd ##1 ofs_rd);
endmodule // dcff_core
`default_nettype wire

// ### dcff_host.sv
// host model driving the buffer's write, read and control pins
`timescale 1ns/1ps
`default_nettype none
module dcff_host
    import dcff_pkg::*;
#(
    parameter int RECOVERY = 2
)
(
    // clock
    input wire logic i_ref_clk,
    // pins toward the buffer
    output logic o_wr_en_n,
    output logic [DCFF_WIDTH-1:0] o_data,
    output logic o_rd_en_n,
    output logic o_offset_load_n,
    output logic o_retransmit_pulse
);
    // standalone part: straps and single chain are set by the bench
    initial
    begin
        o_wr_en_n = 1'b1;
        o_data = 18'h3ffff;
        o_rd_en_n = 1'b1;
        o_offset_load_n = 1'b1;
        o_retransmit_pulse = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one word or distance per call, load_n picks the target
    task automatic put(input logic load_n, input logic [DCFF_WIDTH-1:0] d);
        @(negedge i_ref_clk);
        o_offset_load_n = load_n;
        o_wr_en_n = 1'b0;
        o_data = d;
        @(negedge i_ref_clk);
        o_wr_en_n = 1'b1;
        // released bus shows the inverse, never a stale copy
        o_data = ~d;
    endtask

    task automatic take(input logic load_n);
        @(negedge i_ref_clk);
        o_offset_load_n = load_n;
        o_rd_en_n = 1'b0;
        @(negedge i_ref_clk);
        o_rd_en_n = 1'b1;
    endtask

    task automatic idle(input logic load_n, input int n);
        @(negedge i_ref_clk);
        o_offset_load_n = load_n;
        repeat (n) @(negedge i_ref_clk);
    endtask

    // only called when no more than the depth was written since reset
    task automatic rewind();
        @(negedge i_ref_clk);
        o_offset_load_n = 1'b1;
        o_retransmit_pulse = 1'b1;
        @(negedge i_ref_clk);
        o_retransmit_pulse = 1'b0;
        // enables stay high through the recovery time
        repeat (RECOVERY) @(negedge i_ref_clk);
    endtask
endmodule // dcff_host
`default_nettype wire

// ### dcff_tb.sv
// self-checking bench for the buffer's flags, distances and rewind
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dcff_pkg::*;
    localparam int DEPTH = 64;
    logic clk;
    logic rst_n;
    logic sync_sel;
    logic wr_en_n;
    logic rd_en_n;
    logic ofs_load_n;
    logic retransmit_pulse;
    logic depth_casc;
    logic first_sel;
    logic wr_casc_in;
    logic rd_casc_in;
    logic wr_ready;
    logic wco;
    logic rco;
    logic [DCFF_WIDTH-1:0] wr_data;
    logic [DCFF_WIDTH-1:0] rd_data;
    dcff_flags_t flags;
    int miscompares = 0;
    int checks_done = 0;
    int ae_dist = 7;
    int af_dist = 7;

    always #2.5 clk = ~clk;

    dcff_core #(.DEPTH(DEPTH)) dut_u (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_wr_en_n(wr_en_n), .i_data(wr_data),
        .o_wr_ready(wr_ready), .i_rd_en_n(rd_en_n), .o_data(rd_data),
        .i_offset_load_n(ofs_load_n), .i_retransmit_pulse(retransmit_pulse),
        .i_almost_flag_sync_select(sync_sel), .i_depth_cascade(depth_casc),
        .i_first_device_select(first_sel), .i_write_cascade_in(wr_casc_in),
        .i_read_cascade_in(rd_casc_in), .o_write_cascade_out(wco),
        .o_read_cascade_out(rco), .o_flags(flags)
    );

    dcff_host host_u (
        .i_ref_clk(clk), .o_wr_en_n(wr_en_n), .o_data(wr_data), .o_rd_en_n(rd_en_n),
        .o_offset_load_n(ofs_load_n), .o_retransmit_pulse(retransmit_pulse)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [17:0] exp, input logic [17:0] got);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [17:0] exp_flags(input int n);
        dcff_flags_t f;
        f.full_n = (n < DEPTH);
        f.almost_full_n = !(DEPTH - n <= af_dist);
        f.half_full_n = !(n > DEPTH / 2);
        f.almost_empty_n = !(n <= ae_dist);
        f.empty_n = (n > 0);
        return {13'h0000, f};
    endfunction

    task automatic complete_run();
        $display("miscompares %0d checks_done %0d", miscompares, checks_done);
        if (miscompares == 0 && checks_done > 0)
        begin
            $display("[ PASS ]");
        end
        else
        begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // cuts a hang short
    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        complete_run();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        sync_sel = 1'b0;
        depth_casc = 1'b0;
        first_sel = 1'b0;
        wr_casc_in = 1'b0;
        rd_casc_in = 1'b0;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        check("reset flags", {13'h0000, DCFF_FLAGS_RST}, {13'h0000, flags});
        check("reset data", 18'h00000, rd_data);
        host_u.take(1'b0);
        check("default empty distance", {6'h00, DCFF_DEF_64}, rd_data);
        host_u.take(1'b0);
        check("default full distance", {6'h00, DCFF_DEF_64}, rd_data);
        // empty side, idle in load mode, leave load, then full and empty again
        host_u.put(1'b0, 18'h3f005);
        host_u.idle(1'b0, 3);
        host_u.idle(1'b1, 2);
        host_u.put(1'b0, 18'h2000a);
        host_u.put(1'b0, 18'h3f004);
        ae_dist = 4;
        af_dist = 10;
        host_u.take(1'b0);
        check("empty distance", 18'h00004, rd_data);
        host_u.take(1'b0);
        check("full distance", 18'h0000a, rd_data);
        check("flags after load", exp_flags(0), {13'h0000, flags});
        // fill one word at a time, flags registered
        for (int i = 1; i <= DEPTH; i++)
        begin
            host_u.put(1'b1, 18'h10000 + 18'(i));
            host_u.idle(1'b1, 2);
            check("fill flags", exp_flags(i), {13'h0000, flags});
        end
        host_u.put(1'b1, 18'h2abcd);
        host_u.idle(1'b1, 3);
        check("flags after refused write", exp_flags(DEPTH), {13'h0000, flags});
        // partial drain with combinational almost flags
        @(negedge clk);
        sync_sel = 1'b1;
        for (int i = 1; i <= 40; i++)
        begin
            host_u.take(1'b1);
            check("drain data", 18'h10000 + 18'(i), rd_data);
            host_u.idle(1'b1, 1);
            check("drain flags", exp_flags(DEPTH - i), {13'h0000, flags});
        end
        host_u.rewind();
        check("flags after rewind", exp_flags(DEPTH), {13'h0000, flags});
        @(negedge clk);
        sync_sel = 1'b0;
        for (int i = 1; i <= DEPTH; i++)
        begin
            host_u.take(1'b1);
            check("replay data", 18'h10000 + 18'(i), rd_data);
            host_u.idle(1'b1, 1);
            check("replay flags", exp_flags(DEPTH - i), {13'h0000, flags});
        end
        // reads on empty are refused and keep the last word
        host_u.take(1'b1);
        host_u.idle(1'b1, 1);
        check("held data", 18'h10000 + 18'(DEPTH), rd_data);
        check("empty flags", exp_flags(0), {13'h0000, flags});
        // second reset in mid-run brings defaults back
        @(negedge clk);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        check("flags after second reset", {13'h0000, DCFF_FLAGS_RST}, {13'h0000, flags});
        host_u.take(1'b0);
        check("distance after second reset", {6'h00, DCFF_DEF_64}, rd_data);
        // depth cascade as first device: half pin carries the write pulse
        @(negedge clk);
        depth_casc = 1'b1;
        for (int i = 1; i <= DEPTH; i++)
        begin
            host_u.put(1'b1, 18'h20000 + 18'(i));
            if (i == 10)
            begin
                check("half pin at ten words", 18'h00000, 18'(flags.half_full_n));
            end
        end
        check("write cascade pulse", 18'h00001, 18'(wco));
        check("half pin with pulse", 18'h00001, 18'(flags.half_full_n));
        check("ready at full", 18'h00001, 18'(wr_ready));
        host_u.idle(1'b1, 1);
        check("write cascade pulse ends", 18'h00000, 18'(wco));
        for (int i = 1; i <= DEPTH; i++)
        begin
            host_u.take(1'b1);
            check("cascade data", 18'h20000 + 18'(i), rd_data);
        end
        check("read cascade pulse", 18'h00001, 18'(rco));
        // both tokens passed on: own writes and reads wait for them
        host_u.put(1'b1, 18'h31234);
        host_u.idle(1'b1, 2);
        check("write without token", 18'h00000, 18'(flags.empty_n));
        @(negedge clk);
        wr_casc_in = 1'b1;
        @(negedge clk);
        wr_casc_in = 1'b0;
        host_u.put(1'b1, 18'h31234);
        host_u.idle(1'b1, 2);
        check("write with token", 18'h00001, 18'(flags.empty_n));
        host_u.take(1'b1);
        check("read without token", 18'h20000 + 18'(DEPTH), rd_data);
        @(negedge clk);
        rd_casc_in = 1'b1;
        @(negedge clk);
        rd_casc_in = 1'b0;
        host_u.take(1'b1);
        check("read with token", 18'h31234, rd_data);
        // a later device of the chain starts without tokens
        @(negedge clk);
        first_sel = 1'b1;
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        host_u.put(1'b1, 18'h35555);
        host_u.idle(1'b1, 2);
        check("later device holds no token", 18'h00000, 18'(flags.empty_n));
        complete_run();
    end
endmodule // tb
`default_nettype wire
